// ### stmr_timer.v
// 16-bit timer with period and second compare channels, interval, event and triggered PWM modes.
// Assumes an APB master on clk_i and asynchronous trigger/event pin input.
// Behaviour
// - Mode 000 is interval: period match clears counter, toggles out0, raises compare0.
// - Period FFFFH: counter wraps to 0000H, compare0 and out0 toggle, no overflow.
// - Interval/event period writes reach shadow at once; missed value matches after wrap.
// - Interval: second compare below period pulses compare1 and toggles out1 per cycle.
// - Second compare above period never matches: no compare1, out1 unchanged.
// - Mode 001 is event count: enable clears counter, loads shadow, counts edges.
// - Event mode: period match clears counter, raises compare0 every period+1 edges.
// - Event mode holds out0 low.
// - Event mode period FFFFH: wrap to 0000H on next edge with compare0, no overflow.
// - Event mode still loads second shadow and raises compare1 on its match.
// - Mode 010 waits for a trigger, then clears counter, counts, drives PWM on out1.
// - Trigger while running clears counter to 0000H and restarts.
// - PWM active width equals second value; period equals period value plus one.
// - Compare0 on tick after period match with clear; compare1 on tick that steps counter onto second value.
// - Triggered PWM loads both shadows only at the starting trigger and at period match clear.
// - Trigger comes from valid pin edge or software trigger bit write.
// - Software triggered PWM toggles out0 once per PWM period.
//
// The register addresses and register access over APB were left to the implementer.
`include "stmr_regs.vh"

module stmr_timer #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire clk_en_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire trigger_event_input_i,
  output reg timer_out_zero_o,
  output reg timer_out_one_o,
  output reg compare0_irq_o,
  output reg compare1_irq_o
);

  // =========================================================
  // Control state
  reg count_enable_bit;
  reg [2:0] prescale_sel;
  reg [2:0] operating_mode_field;
  reg event_clock_select;
  reg trig_rise_en;
  reg trig_fall_en;
  reg compare1_irq_mask;
  reg [W-1:0] counter;
  reg [`STMR_PRE_W-1:0] prescale;
  reg cc0_flag;
  reg cc1_flag;
  reg soft_trig_seen;
  reg ce_q;
  reg cc0_pending;

  // State machine of the trigger mode
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;
  reg [2:0] state;
  reg [2:0] next_state;

  wire [W-1:0] period_compare_reg;
  wire [W-1:0] period_compare_shadow;
  wire [W-1:0] second_compare_reg;
  wire [W-1:0] second_compare_shadow;
  wire match0;
  wire match1;
  wire pin_level;
  wire pin_rise;
  wire pin_fall;

  // =========================================================
  // APB decode
  wire apb_wr = psel_i & penable_i & pwrite_i & clk_en_i;
  wire apb_rd_setup = psel_i & ~penable_i & ~pwrite_i;
  wire wr_ctrl0 = apb_wr & (paddr_i == `STMR_OFS_CTRL0);
  wire wr_ctrl1 = apb_wr & (paddr_i == `STMR_OFS_CTRL1);
  wire wr_period = apb_wr & (paddr_i == `STMR_OFS_PERIOD);
  wire wr_second = apb_wr & (paddr_i == `STMR_OFS_SECOND);
  wire wr_status = apb_wr & (paddr_i == `STMR_OFS_STATUS);
  wire addr_ok = (paddr_i == `STMR_OFS_CTRL0) | (paddr_i == `STMR_OFS_CTRL1) |
                 (paddr_i == `STMR_OFS_PERIOD) | (paddr_i == `STMR_OFS_SECOND) |
                 (paddr_i == `STMR_OFS_COUNT) | (paddr_i == `STMR_OFS_STATUS);

  // Software trigger: a write of one to the trigger bit
  wire soft_trig = wr_ctrl1 & pwdata_i[`STMR_CTRL1_EST];

  // =========================================================
  // Mode decode
  wire mode_int = (operating_mode_field == `STMR_MODE_INTERVAL);
  wire mode_evt = (operating_mode_field == `STMR_MODE_EVENT);
  wire mode_pwm = (operating_mode_field == `STMR_MODE_TRIGPWM);

  // =========================================================
  // Pin synchroniser and edge selection
  // The pin passes two flip-flops before any logic reads it, so edges lag by two clocks
  stmr_sync u_pin (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(clk_en_i),
    .async_i(trigger_event_input_i),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );
  wire pin_edge = (trig_rise_en & pin_rise) | (trig_fall_en & pin_fall);
  wire ext_trig = mode_pwm & pin_edge;
  wire trig = mode_pwm & (ext_trig | soft_trig);

  // =========================================================
  // Count tick: prescaled clock, or pin edges in event mode / event clock
  wire pre_tick = (prescale_sel == 3'h0) ? 1'b1 :
                  (prescale[prescale_sel - 3'h1] & ~|(prescale & ((8'h01 << (prescale_sel - 3'h1)) - 8'h01)));
  // The event clock in interval mode lets the pin pace the toggling outputs
  wire use_edge = mode_evt | (mode_int & event_clock_select);
  wire tick = clk_en_i & count_enable_bit & (use_edge ? pin_edge : pre_tick);

  // Enable rising edge starts the counter in interval and event modes
  wire start = count_enable_bit & ~ce_q & (mode_int | mode_evt);
  wire running = count_enable_bit & ~start & (mode_pwm ? (state == ST_RUN) : 1'b1);

  // Period match clear of the counter
  wire clr_int = running & tick & match0 & ~mode_pwm;
  wire clr_pwm = running & tick & match0 & mode_pwm;
  // Batch load at period clear, or start load in trigger mode
  wire batch_load = mode_pwm & (clr_pwm | (trig & (state == ST_WAIT)));
  wire direct = ~mode_pwm;
  // Trigger mode drops out1 as the counter steps onto the second value, so the
  // active level lasts exactly that many ticks; other modes flag the match tick
  wire [W-1:0] count_step = counter + {{(W-1){1'b0}}, 1'b1};
  wire early1 = (count_step == second_compare_shadow);
  wire hit1 = mode_pwm ? early1 : match1;
  // A period match outranks the second match, so a full-width pulse stays high
  wire cmp1_hit = running & tick & hit1 & ~match0;
  // Width the second shadow holds after this edge; a restart must use the new one
  wire [W-1:0] second_next = batch_load ? (wr_second ? pwdata_i[W-1:0] : second_compare_reg) :
                             second_compare_shadow;

  // =========================================================
  // Compare channels
  stmr_cmp #(.W(W)) u_period (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(clk_en_i),
    .wr_i(wr_period),
    .wdata_i(pwdata_i[W-1:0]),
    .direct_i(direct),
    .load_i(batch_load | start),
    .count_i(counter),
    .reg_o(period_compare_reg),
    .shadow_o(period_compare_shadow),
    .match_o(match0)
  );
  stmr_cmp #(.W(W)) u_second (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(clk_en_i),
    .wr_i(wr_second),
    .wdata_i(pwdata_i[W-1:0]),
    .direct_i(direct),
    .load_i(batch_load | start),
    .count_i(counter),
    .reg_o(second_compare_reg),
    .shadow_o(second_compare_shadow),
    .match_o(match1)
  );

  // =========================================================
  // Trigger state machine
  // Clearing the enable or leaving trigger mode drops back to idle at once
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (count_enable_bit && mode_pwm) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!count_enable_bit || !mode_pwm) begin
          next_state = ST_IDLE;
        end else if (trig) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!count_enable_bit || !mode_pwm) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // =========================================================
  // Control registers, counter, prescaler and state
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_enable_bit <= 1'b0;
      prescale_sel <= 3'h0;
      operating_mode_field <= `STMR_MODE_INTERVAL;
      event_clock_select <= 1'b0;
      trig_rise_en <= 1'b0;
      trig_fall_en <= 1'b0;
      compare1_irq_mask <= 1'b0;
      counter <= `STMR_CNT_IDLE;
      prescale <= {`STMR_PRE_W{1'b0}};
      state <= ST_IDLE;
      ce_q <= 1'b0;
      soft_trig_seen <= 1'b0;
      cc0_pending <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_ctrl0) begin
        count_enable_bit <= pwdata_i[`STMR_CTRL0_CE];
        prescale_sel <= pwdata_i[`STMR_CTRL0_PRE_MSB:`STMR_CTRL0_PRE_LSB];
      end
      if (wr_ctrl1) begin
        operating_mode_field <= pwdata_i[`STMR_CTRL1_MD_MSB:`STMR_CTRL1_MD_LSB];
        event_clock_select <= pwdata_i[`STMR_CTRL1_EEE];
        trig_rise_en <= pwdata_i[`STMR_CTRL1_TRG_RISE];
        trig_fall_en <= pwdata_i[`STMR_CTRL1_TRG_FALL];
        compare1_irq_mask <= pwdata_i[`STMR_CTRL1_MASK1];
      end
      ce_q <= count_enable_bit;
      state <= next_state;
      prescale <= count_enable_bit ? prescale + 8'h01 : {`STMR_PRE_W{1'b0}};
      // Remember a software trigger source for the out0 square wave
      if (soft_trig) begin
        soft_trig_seen <= 1'b1;
      end else if (ext_trig || !count_enable_bit) begin
        soft_trig_seen <= 1'b0;
      end
      // Compare0 in trigger mode follows the clear by one count tick
      if (!mode_pwm || trig || !count_enable_bit) begin
        cc0_pending <= 1'b0;
      end else if (clr_pwm) begin
        cc0_pending <= 1'b1;
      end else if (tick) begin
        cc0_pending <= 1'b0;
      end
      // A trigger outranks a period match, so a restart never loses its clear
      if (!count_enable_bit) begin
        counter <= `STMR_CNT_IDLE;
      end else if (start) begin
        counter <= `STMR_CNT_ZERO;
      end else if (trig) begin
        counter <= `STMR_CNT_ZERO;
      end else if (clr_int || clr_pwm) begin
        counter <= `STMR_CNT_ZERO;
      end else if (running && tick) begin
        // Plain binary wrap from FFFFH to 0000H; no overflow state exists
        counter <= counter + `STMR_CNT_ONE;
      end
    end
  end

  // =========================================================
  // Compare pulses; trigger suppresses a coincident match
  wire cc0_ev = clr_int | (cc0_pending & tick & ~trig);
  wire cc1_ev = (cmp1_hit & ~trig) | (match1 & match0 & running & tick & ~mode_pwm);

  // Pulses, outputs and sticky status
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      compare0_irq_o <= 1'b0;
      compare1_irq_o <= 1'b0;
      timer_out_zero_o <= 1'b0;
      timer_out_one_o <= 1'b0;
      cc0_flag <= 1'b0;
      cc1_flag <= 1'b0;
    end else if (clk_en_i) begin
      compare0_irq_o <= cc0_ev;
      compare1_irq_o <= cc1_ev & ~compare1_irq_mask;
      // Status flags: set wins over clear
      cc0_flag <= cc0_ev | (cc0_flag & ~(wr_status & pwdata_i[`STMR_STAT_CC0]));
      cc1_flag <= cc1_ev | (cc1_flag & ~(wr_status & pwdata_i[`STMR_STAT_CC1]));
      if (!count_enable_bit) begin
        timer_out_zero_o <= 1'b0;
        timer_out_one_o <= 1'b0;
      end else if (mode_int) begin
        if (start || clr_int) begin
          timer_out_zero_o <= ~timer_out_zero_o;
        end
        if (cc1_ev) begin
          timer_out_one_o <= ~timer_out_one_o;
        end
      end else if (mode_evt) begin
        timer_out_zero_o <= 1'b0;
      end else if (mode_pwm) begin
        if ((soft_trig_seen || soft_trig) && (trig || clr_pwm)) begin
          timer_out_zero_o <= ~timer_out_zero_o;
        end
        if (trig || clr_pwm) begin
          // A zero width keeps out1 inactive for the whole period
          timer_out_one_o <= (second_next != `STMR_CNT_ZERO);
        end else if (cmp1_hit) begin
          timer_out_one_o <= 1'b0;
        end
      end
    end
  end

  // =========================================================
  // APB answer: zero wait states, error on unmapped address
  // Writes to the count register or an unmapped address change nothing
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (clk_en_i) begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_ok;
      if (apb_rd_setup) begin
        case (paddr_i)
          `STMR_OFS_CTRL0: prdata_o <= {28'h0000000, prescale_sel, count_enable_bit};
          `STMR_OFS_CTRL1: prdata_o <= {19'h00000, compare1_irq_mask, 2'h0, trig_fall_en, trig_rise_en,
                                        3'h0, event_clock_select, 1'b0, operating_mode_field};
          `STMR_OFS_PERIOD: prdata_o <= {16'h0000, period_compare_reg};
          `STMR_OFS_SECOND: prdata_o <= {16'h0000, second_compare_reg};
          `STMR_OFS_COUNT: prdata_o <= {16'h0000, count_enable_bit ? counter : `STMR_CNT_ZERO};
          `STMR_OFS_STATUS: prdata_o <= {28'h0000000, pin_level, state == ST_RUN, cc1_flag, cc0_flag};
          default: prdata_o <= 32'h00000000;
        endcase
      end else begin
        prdata_o <= 32'h00000000;
      end
    end
  end

endmodule // stmr_timer

// ### stmr_regs.vh
// Register map, field positions, reset values and timing constants of the timer unit.
// Assumes inclusion by the timer top module and its helpers; definitions only.
`ifndef STMR_REGS_VH
`define STMR_REGS_VH

// =========================================================
// Register byte offsets on the APB
`define STMR_OFS_CTRL0 12'h000
`define STMR_OFS_CTRL1 12'h004
`define STMR_OFS_PERIOD 12'h008
`define STMR_OFS_SECOND 12'h00C
`define STMR_OFS_COUNT 12'h010
`define STMR_OFS_STATUS 12'h014

// =========================================================
// Field positions
`define STMR_CTRL0_CE 0
`define STMR_CTRL0_PRE_LSB 1
`define STMR_CTRL0_PRE_MSB 3
`define STMR_CTRL1_MD_LSB 0
`define STMR_CTRL1_MD_MSB 2
`define STMR_CTRL1_EEE 4
`define STMR_CTRL1_EST 6
`define STMR_CTRL1_TRG_RISE 8
`define STMR_CTRL1_TRG_FALL 9
`define STMR_CTRL1_MASK1 12
`define STMR_STAT_CC0 0
`define STMR_STAT_CC1 1

// =========================================================
// Mode codes and reset values
`define STMR_MODE_INTERVAL 3'h0
`define STMR_MODE_EVENT 3'h1
`define STMR_MODE_TRIGPWM 3'h2
`define STMR_CNT_IDLE 16'hFFFF
`define STMR_CNT_ZERO 16'h0000
`define STMR_CNT_ONE 16'h0001
`define STMR_RST_CTRL 16'h0000
`define STMR_RST_CMP 16'h0000

// =========================================================
// Prescaler: count tick every 2^pre clocks, pre is 0..7
`define STMR_PRE_W 8

`endif

// ### stmr_sync.v
// Two-flip-flop synchroniser with rising/falling edge pulses on the synchronised level.
// Assumes an input from outside the clock domain and a clock enable shared with the timer.
module stmr_sync (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire async_i,
  output reg level_o,
  output wire rise_o,
  output wire fall_o
);

  // =========================================================
  // Synchroniser stages plus one history stage
  reg meta;
  reg hist;

  // First stage is read only by the second stage
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      level_o <= 1'b0;
      hist <= 1'b0;
    end else if (ce_i) begin
      meta <= async_i;
      level_o <= meta;
      hist <= level_o;
    end
  end

  // Edge pulses from the settled level only
  assign rise_o = ce_i & level_o & ~hist;
  assign fall_o = ce_i & ~level_o & hist;

endmodule // stmr_sync

// ### stmr_cmp.v
// One compare channel: software register, shadow buffer and equality against the counter.
// Assumes load strobes come from the timer's control logic on the same clock.
module stmr_cmp #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire wr_i,
  input wire [W-1:0] wdata_i,
  input wire direct_i,
  input wire load_i,
  input wire [W-1:0] count_i,
  output reg [W-1:0] reg_o,
  output reg [W-1:0] shadow_o,
  output wire match_o
);

  // =========================================================
  // Register and shadow; immediate mode writes through to the shadow
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_o <= {W{1'b0}};
      shadow_o <= {W{1'b0}};
    end else if (ce_i) begin
      if (wr_i) begin
        reg_o <= wdata_i;
      end
      if (wr_i && direct_i) begin
        shadow_o <= wdata_i;
      end else if (load_i) begin
        shadow_o <= wr_i ? wdata_i : reg_o;
      end
    end
  end

  // Match of counter with the shadow
  assign match_o = (count_i == shadow_o);

endmodule // stmr_cmp

// ### stmr_timer_properties.sv
// Concurrent checks on the timer's APB answer and its output pins.
// Assumes it is bound into stmr_timer and sees only that module's ports.
`include "stmr_regs.vh"

module stmr_timer_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic trigger_event_input_i,
  input wire logic timer_out_zero_o,
  input wire logic timer_out_one_o,
  input wire logic compare0_irq_o,
  input wire logic compare1_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // =========================================================
  // Clocking and reset for every property
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // =========================================================
  // APB answer
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  a_ready_timely: assert property (psel_i && !penable_i && clk_en_i ##1 clk_en_i |-> pready_o)
    else $error("no pready in the access cycle");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside an access phase");
  a_err_only_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero outside an answer");
  a_err_unmapped: assert property (pready_o && paddr_i > `STMR_OFS_STATUS |-> pslverr_o)
    else $error("unmapped address answered without error");
  a_no_err_mapped: assert property (pready_o && paddr_i <= `STMR_OFS_STATUS && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("mapped register answered with error");
  a_est_reads_zero: assert property (
    pready_o && !pwrite_i && paddr_i == `STMR_OFS_CTRL1 |-> !prdata_o[`STMR_CTRL1_EST])
    else $error("software trigger bit read back as one");
  a_cmp_upper_zero: assert property (pready_o && !pwrite_i &&
    (paddr_i == `STMR_OFS_PERIOD || paddr_i == `STMR_OFS_SECOND) |-> prdata_o[31:16] == 16'h0)
    else $error("compare register upper half not zero");
  // =========================================================
  // Outputs quiet on the first edge after reset
  a_out_quiet_reset: assert property ($rose(rst_n_i) |->
    !timer_out_zero_o && !timer_out_one_o && !compare0_irq_o && !compare1_irq_o)
    else $error("output active right after reset");
endmodule // stmr_timer_properties

bind stmr_timer stmr_timer_properties u_stmr_timer_properties (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .clk_en_i(clk_en_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .trigger_event_input_i(trigger_event_input_i), .timer_out_zero_o(timer_out_zero_o),
  .timer_out_one_o(timer_out_one_o), .compare0_irq_o(compare0_irq_o), .compare1_irq_o(compare1_irq_o));

// ### stmr_pin_model.sv
// Behavioural driver of the trigger or event pin seen by the timer.
// Assumes the bench calls pulses right after a rising clock edge.
module stmr_pin_model (
  input wire logic clk_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // =========================================================
  // Pin rests low between pulses, as with a pull-down
  initial begin
    pin_o = 1'b0;
  end
  // Each pulse gives one rising and one falling edge
  task automatic pulses(input int k, input int gap);
    repeat (k) begin
      pin_o <= 1'b1;
      repeat (gap) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (gap) @(posedge clk_i);
    end
  endtask
endmodule // stmr_pin_model

// ### stmr_timer_tb.sv
// Self-checking bench: APB tasks program the timer, the pin model gives edges.
// Assumes stmr_timer, its register header and the pin model.
`include "stmr_regs.vh"

module stmr_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, e, pin, o0, o1, i0, i1, p0 = 0, p1 = 0, prdy, perr;
  logic [11:0] pa = 12'h000;
  logic cen = 1'b1;
  logic [31:0] pwd = 32'h0, prd, r;
  logic [11:0] ofs[5] = '{`STMR_OFS_CTRL0, `STMR_OFS_CTRL1, `STMR_OFS_PERIOD, `STMR_OFS_SECOND, `STMR_OFS_COUNT};
  int fails = 0, checks = 0, cyc = 0, mg = 999, w = 0, k;
  int n[4] = '{0, 0, 0, 0}, g[4] = '{0, 0, 0, 0}, l[4] = '{0, 0, 0, 0}, b[4];
  wire [3:0] ev = {o1 & ~p1, o0 ^ p0, i1, i0};

  // =========================================================
  // Clock and design
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  stmr_timer u_stmr_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(cen), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .trigger_event_input_i(pin), .timer_out_zero_o(o0), .timer_out_one_o(o1), .compare0_irq_o(i0),
    .compare1_irq_o(i1));
  stmr_pin_model u_stmr_pin_model (.clk_i(clk_i), .pin_o(pin));

  // =========================================================
  // Event recorder: counts, gaps, out1 high width, shortest out1 period
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    p0 <= o0;
    p1 <= o1;
    if (p1 && !o1) w <= cyc - l[3];
    if (ev[3] && cyc - l[3] < mg) mg <= cyc - l[3];
    for (int i = 0; i < 4; i++) begin
      if (ev[i]) begin
        n[i] <= n[i] + 1;
        g[i] <= cyc - l[i];
        l[i] <= cyc;
      end
    end
  end

  // =========================================================
  // Compare, bus and wait tasks
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    checks++;
    if (got != exp) begin
      fails++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic xf(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic f);
    psel <= 1'b1;
    pwr <= wr;
    pa <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (prdy !== 1'b1);
    q = prd;
    f = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xf(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    xf(1'b0, a, 32'h0, r, e);
    chk_v(r, x);
  endtask
  task automatic run(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic wt(input int i, input int lim);
    k = 0;
    b = n;
    while (n[i] == b[i] && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    chk_n(k < lim, 1);
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // =========================================================
  // Watchdog: the wrap test needs about 66000 cycles, the rest a few hundred
  initial begin
    #(90000 * 8);
    fails++;
    end_of_test;
  end

  // =========================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (ofs[i]) rdc(ofs[i], 32'h0);
    xf(1'b0, 12'h020, 32'h0, r, e);
    chk_v({31'h0, e}, 32'h1);
    $display("reset test done");
    wr(`STMR_OFS_PERIOD, 32'h4);
    wr(`STMR_OFS_SECOND, 32'h2);
    wr(`STMR_OFS_CTRL0, 32'h1);
    run(60);
    chk_n(g[0], 5);
    chk_n(g[2], 5);
    chk_n(g[1], 5);
    chk_n(g[3], 10);
    wr(`STMR_OFS_CTRL0, 32'h0);
    wr(`STMR_OFS_SECOND, 32'h9);
    wr(`STMR_OFS_CTRL0, 32'h1);
    b = n;
    run(60);
    chk_n(n[1] - b[1], 0);
    chk_n(n[3] - b[3], 0);
    wr(`STMR_OFS_CTRL0, 32'h0);
    wr(`STMR_OFS_SECOND, 32'h2);
    wr(`STMR_OFS_CTRL1, 32'h1000);
    wr(`STMR_OFS_CTRL0, 32'h1);
    b = n;
    run(30);
    chk_n(n[1] - b[1], 0);
    // Prescale by two, then freeze everything with the clock enable
    wr(`STMR_OFS_CTRL0, 32'h3);
    run(40);
    chk_n(g[2], 10);
    cen <= 1'b0;
    run(2);
    b = n;
    run(20);
    chk_n(n[2] - b[2], 0);
    cen <= 1'b1;
    $display("interval test done");
    wr(`STMR_OFS_CTRL0, 32'h0);
    wr(`STMR_OFS_CTRL1, 32'h0);
    wr(`STMR_OFS_PERIOD, 32'h64);
    wr(`STMR_OFS_CTRL0, 32'h1);
    wt(0, 200);
    run(60);
    wr(`STMR_OFS_PERIOD, 32'hA);
    wt(0, 70000);
    chk_n(g[0], 65547);
    wt(0, 100);
    chk_n(g[0], 11);
    $display("period rewrite test done");
    wr(`STMR_OFS_CTRL0, 32'h0);
    wr(`STMR_OFS_PERIOD, 32'h3);
    wr(`STMR_OFS_SECOND, 32'h1);
    wr(`STMR_OFS_CTRL1, 32'h101);
    wr(`STMR_OFS_CTRL0, 32'h1);
    run(4);
    b = n;
    u_stmr_pin_model.pulses(8, 4);
    run(10);
    chk_n(n[0] - b[0], 2);
    chk_n(n[1] - b[1], 2);
    chk_n(n[2] - b[2], 0);
    $display("event test done");
    wr(`STMR_OFS_CTRL0, 32'h0);
    wr(`STMR_OFS_PERIOD, 32'h9);
    wr(`STMR_OFS_SECOND, 32'h3);
    wr(`STMR_OFS_CTRL1, 32'h102);
    wr(`STMR_OFS_CTRL0, 32'h1);
    b = n;
    run(20);
    chk_n(n[3] - b[3], 0);
    chk_n(n[0] - b[0], 0);
    wr(`STMR_OFS_CTRL1, 32'h142);
    run(45);
    rdc(`STMR_OFS_CTRL1, 32'h102);
    chk_n(g[3], 10);
    chk_n(w, 3);
    chk_n(g[0], 10);
    chk_n(g[1], 10);
    chk_n(g[2], 10);
    wt(0, 40);
    mg = 999;
    run(1);
    u_stmr_pin_model.pulses(1, 3);
    run(20);
    chk_n(mg < 10, 1);
    $display("trigger test done");
    end_of_test;
  end
endmodule // stmr_timer_tb
